// file: logic/pcs_core_reg.sv
// Combined program counter and status register with its access paths
`timescale 1ns/1ns
`include "pcs_defines.svh"
`default_nettype none
// Functional notes
// - Program counter lives in bits 25 to 2
// - Flags, masks high; mode field low
// - Four modes; aborts enter supervisor
// - User mode cannot write masks or mode except by status-restoring returns
// - First-operand read gives program counter only
// - Second-operand read gives all 32 bits
// - Stores write all 32 bits
// - Link and non-address exceptions copy whole register
// - Plain writes change program counter only
// - Flag-setting writes change counter and status
// - Status-restoring returns allowed in user mode
// - No separate status move instructions
// - Destination all ones selects status-write variant
// - Opcode picks AND, XOR, subtract, add
// - User mode writes flags only
// - Status-write runs only when condition passes
// - Bit 25 selects immediate or register operand
// - Top six address bits set raise exception
// - Address exception: link, supervisor, mask, 0x14
// - Mode codes 00 user to 11 supervisor
module pcs_core_reg (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_advance,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_first_reg,
  input wire logic [31:0] i_imm_operand,
  input wire logic [31:0] i_reg_operand,
  input wire pcs_pkg::pcs_write_t i_write,
  input wire logic i_restore_is_return,
  input wire pcs_pkg::pcs_data_access_t i_data,
  input wire pcs_pkg::pcs_exc_t i_exc,
  input wire logic i_branch_link,
  input wire logic [31:0] i_instr_addr,
  output logic [31:0] o_combined,
  output logic [31:0] o_first_operand_view,
  output logic [31:0] o_second_operand_view,
  output logic [31:0] o_store_value,
  output logic [31:0] o_fetch_addr,
  output logic o_link_we,
  output logic [31:0] o_link_value,
  output logic o_link_is_svc,
  output logic o_addr_exception,
  output logic o_status_write_taken,
  output logic [1:0] o_mode
);
  import pcs_pkg::*;

  logic [31:0] reg_q; // Combined register
  logic [31:0] reg_d; // Next value of the combined register
  logic link_we_q; // Link write strobe
  logic [31:0] link_value_q; // Value for the link register
  logic link_svc_q; // Link goes to supervisor bank
  logic addr_exc_q; // Address exception seen last cycle
  logic sw_taken_q; // Status-write executed last cycle
  logic [31:0] alu_result; // Result of status-write operation
  logic [31:0] shifter_operand; // Selected shifter operand
  logic cond_pass; // Condition matches flags
  logic is_compare_class; // Compare/test with status set bit
  logic is_status_write; // Status-write variant decoded
  logic do_status_write; // Status-write executes now
  logic addr_fault; // Data address out of range
  logic user_mode; // Currently in user mode
  logic [31:0] protect_mask; // Bits the current mode may write

  assign user_mode = reg_q[1:0] == PCS_MODE_USER;
  assign o_mode = reg_q[1:0];
  assign o_combined = reg_q;

  // Reads of the combined register in its different roles
  always_comb begin
    o_first_operand_view = 32'h00000000;
    o_first_operand_view[`PCS_PC_HI:`PCS_PC_LO] = reg_q[`PCS_PC_HI:`PCS_PC_LO];
  end
  assign o_second_operand_view = reg_q;
  assign o_store_value = reg_q;

  // Fetch address formed from the word counter
  assign o_fetch_addr = {6'h00, reg_q[`PCS_PC_HI:`PCS_PC_LO], 2'b00};

  // Decode of the compare/test family with the destination field all ones
  assign is_compare_class = i_instr[27:26] == 2'b00 && i_instr[24:23] == 2'b10 &&
    i_instr[20];
  assign is_status_write = i_instr_valid && is_compare_class &&
    i_instr[15:12] == `PCS_DEST_ALL_ONES;
  // Compares/tests and status-only write requests reach the status part without a counter write
  // Move-to and move-from status forms are not decoded at all

  // Operand form chosen by instruction bit 25
  assign shifter_operand = i_instr[25] ? i_imm_operand : i_reg_operand;

  pcs_status_alu u_alu (
    .i_op(pcs_op_t'(i_instr[22:21])),
    .i_first_operand(i_first_reg),
    .i_shifter_operand(shifter_operand),
    .o_result(alu_result)
  );

  pcs_cond_check u_cond (
    .i_cond(i_instr[31:28]),
    .i_flags(reg_q[`PCS_FLAG_HI:`PCS_FLAG_LO]),
    .o_pass(cond_pass)
  );

  assign do_status_write = is_status_write && cond_pass;

  // Data address range check on the top six bits
  assign addr_fault = i_data.valid && (|i_data.addr[`PCS_ADDR_TOP_HI:`PCS_ADDR_TOP_LO]);

  // Bits the current mode may change on a status write
  always_comb begin
    protect_mask = 32'hffffffff;
    if (user_mode && !i_restore_is_return) begin
      protect_mask[`PCS_IMASK_BIT] = 1'b0;
      protect_mask[`PCS_FMASK_BIT] = 1'b0;
      protect_mask[1:0] = 2'b00;
    end
  end

  // Next value of the combined register, exceptions first
  always_comb begin
    reg_d = reg_q;
    if (addr_fault) begin
      reg_d = `PCS_VEC_ADDR_EXC;
      reg_d[`PCS_FLAG_HI:`PCS_FLAG_LO] = reg_q[`PCS_FLAG_HI:`PCS_FLAG_LO];
      reg_d[`PCS_IMASK_BIT] = 1'b1;
      reg_d[`PCS_FMASK_BIT] = reg_q[`PCS_FMASK_BIT];
      reg_d[1:0] = 2'(`PCS_FULL_MODE_SVC);
    end else if (i_exc.valid) begin
      reg_d[`PCS_PC_HI:`PCS_PC_LO] = i_exc.vector[`PCS_PC_HI:`PCS_PC_LO];
      reg_d[`PCS_IMASK_BIT] = reg_q[`PCS_IMASK_BIT] | i_exc.set_imask;
      reg_d[`PCS_FMASK_BIT] = reg_q[`PCS_FMASK_BIT] | i_exc.set_fmask;
      reg_d[1:0] = i_exc.mode;
    end else if (do_status_write) begin
      if (user_mode) begin
        reg_d[`PCS_FLAG_HI:`PCS_FLAG_LO] = alu_result[31:28];
      end else begin
        reg_d[31:26] = alu_result[31:26];
        reg_d[1:0] = alu_result[1:0];
      end
    end else begin
      case (i_write.kind)
        PCS_WR_PC_ONLY: begin
          reg_d[`PCS_PC_HI:`PCS_PC_LO] = i_write.value[`PCS_PC_HI:`PCS_PC_LO];
        end
        PCS_WR_PC_STATUS: begin
          reg_d = (i_write.value & protect_mask) | (reg_q & ~protect_mask);
        end
        PCS_WR_STATUS_ONLY: begin
          reg_d[31:26] = (i_write.value[31:26] & protect_mask[31:26]) |
            (reg_q[31:26] & ~protect_mask[31:26]);
          reg_d[1:0] = (i_write.value[1:0] & protect_mask[1:0]) |
            (reg_q[1:0] & ~protect_mask[1:0]);
        end
        default: begin
          if (i_advance) begin
            reg_d[`PCS_PC_HI:`PCS_PC_LO] = reg_q[`PCS_PC_HI:`PCS_PC_LO] + 24'h000001;
          end
        end
      endcase
    end
  end

  // Combined register update
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      reg_q <= `PCS_RESET_VALUE;
    end else begin
      reg_q <= reg_d;
    end
  end

  // Link register value on branch-with-link and exception entry
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      link_we_q <= 1'b0;
      link_value_q <= 32'h00000000;
      link_svc_q <= 1'b0;
    end else begin
      link_we_q <= addr_fault || i_exc.valid || i_branch_link;
      link_svc_q <= addr_fault || (i_exc.valid && i_exc.mode == PCS_MODE_SVC);
      if (addr_fault) begin
        link_value_q <= {reg_q[31:26], 26'h0000000} |
          {6'h00, (i_instr_addr[25:0] + 26'h0000004) & 26'h3fffffc} | {30'h0, reg_q[1:0]};
      end else if (i_exc.valid || i_branch_link) begin
        link_value_q <= reg_q;
      end
    end
  end
  assign o_link_we = link_we_q;
  assign o_link_value = link_value_q;
  assign o_link_is_svc = link_svc_q;

  // Event flags for the surrounding core
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      addr_exc_q <= 1'b0;
      sw_taken_q <= 1'b0;
    end else begin
      addr_exc_q <= addr_fault;
      sw_taken_q <= do_status_write && !addr_fault && !i_exc.valid;
    end
  end
  assign o_addr_exception = addr_exc_q;
  assign o_status_write_taken = sw_taken_q;

  // Address exception lands at the fixed vector in supervisor mode
  a_addr_exc_entry: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    addr_fault |=> (o_fetch_addr == `PCS_VEC_ADDR_EXC && o_mode == 2'b11 && reg_q[27]))
    else $error("address exception entry wrong");

  // Address exception link holds the next instruction and the flags
  a_addr_link_value: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    addr_fault |=> (o_link_we && o_link_is_svc &&
     o_link_value[25:2] == $past(i_instr_addr[25:2]) + 24'h000001 &&
     o_link_value[31:26] == $past(reg_q[31:26])))
    else $error("address exception link value wrong");

  // Exception flag follows a high top address bit
  a_addr_range_chk: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_data.valid && i_data.addr[31]) |=> o_addr_exception)
    else $error("out of range address not flagged");

  // Lowest of the checked address bits faults as well
  a_low_bit_exc: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_data.valid && i_data.addr[26]) |=> o_addr_exception)
    else $error("address bit 26 not flagged");

  // Addresses inside the low 64 megabytes never fault
  a_no_false_exc: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !(i_data.valid && (|i_data.addr[31:26])) |=> !o_addr_exception)
    else $error("in range address flagged");

  // First-operand view carries only the counter bits
  a_first_view_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_first_operand_view[31:26] == 6'h00 && o_first_operand_view[1:0] == 2'b00)
    else $error("first operand view leaks status");

  // User mode status write leaves masks and mode intact
  a_user_flags_only: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (do_status_write && user_mode && !addr_fault && !i_exc.valid) |=>
    (reg_q[27:26] == $past(reg_q[27:26]) && reg_q[1:0] == 2'b00 &&
     reg_q[31:28] == $past(alu_result[31:28])))
    else $error("user status write changed protected bits");

  // Privileged status write takes status and mode bits from the result
  a_priv_status_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (do_status_write && !user_mode && !addr_fault && !i_exc.valid) |=>
    (reg_q[31:26] == $past(alu_result[31:26]) && reg_q[1:0] == $past(alu_result[1:0])))
    else $error("privileged status write wrong");

  // Status write result follows the two-bit opcode
  a_alu_result: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    is_status_write |-> (alu_result ==
     ((i_instr[22:21] == 2'b00) ? (i_first_reg & shifter_operand) :
      (i_instr[22:21] == 2'b01) ? (i_first_reg ^ shifter_operand) :
      (i_instr[22:21] == 2'b10) ? (i_first_reg - shifter_operand) :
      (i_first_reg + shifter_operand))))
    else $error("status write result wrong");

  // Status write leaves the counter where it was
  a_status_pc_kept: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (do_status_write && !addr_fault && !i_exc.valid) |=>
    reg_q[`PCS_PC_HI:`PCS_PC_LO] == $past(reg_q[`PCS_PC_HI:`PCS_PC_LO]))
    else $error("status write moved the counter");

  // Failed condition leaves the register untouched
  a_cond_fail_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (is_status_write && !cond_pass && !addr_fault && !i_exc.valid &&
     i_write.kind == PCS_WR_NONE && !i_advance) |=> $stable(reg_q))
    else $error("status write ran on failed condition");

  // Passing condition reports the status write as taken
  a_cond_pass_runs: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (is_status_write && cond_pass && !addr_fault && !i_exc.valid) |=> o_status_write_taken)
    else $error("passing status write not taken");

  // Failing condition never reports a status write
  a_cond_fail_quiet: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (is_status_write && !cond_pass) |=> !o_status_write_taken)
    else $error("failing status write reported");

  // Plain counter write keeps the status part
  a_pc_only_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write.kind == PCS_WR_PC_ONLY && !do_status_write && !addr_fault && !i_exc.valid)
    |=> (reg_q[31:26] == $past(reg_q[31:26]) && reg_q[1:0] == $past(reg_q[1:0])))
    else $error("counter-only write changed status");

  // Flag-setting write outside user mode takes the whole value
  a_pc_status_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write.kind == PCS_WR_PC_STATUS && !user_mode && !do_status_write && !addr_fault &&
     !i_exc.valid) |=> reg_q == $past(i_write.value))
    else $error("counter and status write wrong");

  // Return form restores everything even from user mode
  a_return_restore: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write.kind == PCS_WR_PC_STATUS && i_restore_is_return && !do_status_write &&
     !addr_fault && !i_exc.valid) |=> reg_q == $past(i_write.value))
    else $error("status restoring return wrong");

  // Status-only write leaves the counter alone
  a_status_only_pc: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_write.kind == PCS_WR_STATUS_ONLY && !do_status_write && !addr_fault && !i_exc.valid)
    |=> reg_q[`PCS_PC_HI:`PCS_PC_LO] == $past(reg_q[`PCS_PC_HI:`PCS_PC_LO]))
    else $error("status-only write moved the counter");

  // Branch with link copies the whole register
  a_link_copy_all: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_branch_link && !addr_fault && !i_exc.valid) |=>
    (o_link_we && o_link_value == $past(reg_q)))
    else $error("link value not full register");

  // Other exception entry copies the whole register to the link
  a_exc_link_copy: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_exc.valid && !addr_fault) |=> (o_link_we && o_link_value == $past(reg_q)))
    else $error("exception link value not full register");

  // Other exception entry takes the requested mode and vector
  a_exc_entry_mode: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_exc.valid && !addr_fault) |=> (o_mode == $past(i_exc.mode) &&
     reg_q[`PCS_PC_HI:`PCS_PC_LO] == $past(i_exc.vector[`PCS_PC_HI:`PCS_PC_LO])))
    else $error("exception entry mode or vector wrong");

  // Sequential advance steps the counter by one word
  a_fetch_advance: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_advance && i_write.kind == PCS_WR_NONE && !do_status_write && !addr_fault &&
     !i_exc.valid) |=> o_fetch_addr[25:0] == $past(o_fetch_addr[25:0]) + 26'h0000004)
    else $error("fetch address did not advance");

  // User-mode write with status never touches masks unless a return
  a_user_mask_lock: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (user_mode && i_write.kind == PCS_WR_PC_STATUS && !i_restore_is_return &&
     !do_status_write && !addr_fault && !i_exc.valid) |=> $stable(reg_q[27:26]))
    else $error("user mode changed interrupt masks");

  // User mode keeps masks and mode unless an exception or a return
  a_user_mode_lock: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (user_mode && !i_restore_is_return && !addr_fault && !i_exc.valid) |=>
    (o_mode == 2'b00 && reg_q[27:26] == $past(reg_q[27:26])))
    else $error("user mode changed masks or mode");
endmodule
`default_nettype wire

// file: logic/pcs_defines.svh
// Constants for the combined program counter and status logic
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_PC_HI 25
`define PCS_PC_LO 2
`define PCS_FLAG_HI 31
`define PCS_FLAG_LO 28
`define PCS_IMASK_BIT 27
`define PCS_FMASK_BIT 26
`define PCS_RESET_VALUE 32'h0c000003
`define PCS_VEC_ADDR_EXC 32'h00000014
`define PCS_VEC_RESET 32'h00000000
`define PCS_LINK_ADJ 32'h00000004
`define PCS_DEST_ALL_ONES 4'hf
`define PCS_ADDR_TOP_HI 31
`define PCS_ADDR_TOP_LO 26
`define PCS_FULL_MODE_SVC 5'h03
`endif

// file: logic/pcs_pkg.sv
// Types for the combined program counter and status logic
package pcs_pkg;
  // Two-bit mode field, low bits of the full mode numbers
  typedef enum logic [1:0] {
    PCS_MODE_USER = 2'b00,
    PCS_MODE_FIQ = 2'b01,
    PCS_MODE_IRQ = 2'b10,
    PCS_MODE_SVC = 2'b11
  } pcs_mode_t;
  // Two-bit opcode of the status-write compares
  typedef enum logic [1:0] {
    PCS_OP_AND = 2'b00,
    PCS_OP_XOR = 2'b01,
    PCS_OP_SUB = 2'b10,
    PCS_OP_ADD = 2'b11
  } pcs_op_t;
  // Kind of write into the combined register
  typedef enum logic [2:0] {
    PCS_WR_NONE = 3'b000,
    PCS_WR_PC_ONLY = 3'b001,
    PCS_WR_PC_STATUS = 3'b010,
    PCS_WR_STATUS_ONLY = 3'b011
  } pcs_wr_t;
  // Write request into the combined register
  typedef struct packed {
    pcs_wr_t kind;
    logic [31:0] value;
  } pcs_write_t;
  // Data access presented for range checking
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } pcs_data_access_t;
  // Exception entry request
  typedef struct packed {
    logic valid;
    logic [31:0] vector;
    logic set_imask;
    logic set_fmask;
    pcs_mode_t mode;
  } pcs_exc_t;
endpackage

// file: logic/pcs_status_alu.sv
// Result computation of the status-write compare and test variants
`timescale 1ns/1ns
`default_nettype none
module pcs_status_alu (
  input wire pcs_pkg::pcs_op_t i_op,
  input wire logic [31:0] i_first_operand,
  input wire logic [31:0] i_shifter_operand,
  output logic [31:0] o_result
);
  import pcs_pkg::*;
  // Select the operation from the two-bit opcode
  always_comb begin
    case (i_op)
      PCS_OP_AND: o_result = i_first_operand & i_shifter_operand;
      PCS_OP_XOR: o_result = i_first_operand ^ i_shifter_operand;
      PCS_OP_SUB: o_result = i_first_operand - i_shifter_operand;
      PCS_OP_ADD: o_result = i_first_operand + i_shifter_operand;
      default: o_result = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

// file: logic/pcs_cond_check.sv
// Condition field check against the current flags
`timescale 1ns/1ns
`default_nettype none
module pcs_cond_check (
  input wire logic [3:0] i_cond,
  input wire logic [3:0] i_flags,
  output logic o_pass
);
  logic n_f, z_f, c_f, v_f; // Individual flags
  assign {n_f, z_f, c_f, v_f} = i_flags;
  // Standard sixteen condition encodings
  always_comb begin
    case (i_cond)
      4'h0: o_pass = z_f;
      4'h1: o_pass = !z_f;
      4'h2: o_pass = c_f;
      4'h3: o_pass = !c_f;
      4'h4: o_pass = n_f;
      4'h5: o_pass = !n_f;
      4'h6: o_pass = v_f;
      4'h7: o_pass = !v_f;
      4'h8: o_pass = c_f && !z_f;
      4'h9: o_pass = !c_f || z_f;
      4'ha: o_pass = n_f == v_f;
      4'hb: o_pass = n_f != v_f;
      4'hc: o_pass = !z_f && (n_f == v_f);
      4'hd: o_pass = z_f || (n_f != v_f);
      4'he: o_pass = 1'b1;
      default: o_pass = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: sim/pcs_stream_model.sv
// Instruction stream and data side model facing the combined register logic
`timescale 1ns/1ns
`default_nettype none
module pcs_stream_model (
  input wire logic i_clk_sys,
  output logic o_advance,
  output logic o_instr_valid,
  output logic [31:0] o_instr,
  output logic [31:0] o_first_reg,
  output logic [31:0] o_imm_operand,
  output logic [31:0] o_reg_operand,
  output var pcs_pkg::pcs_write_t o_write,
  output logic o_restore_is_return,
  output var pcs_pkg::pcs_data_access_t o_data,
  output var pcs_pkg::pcs_exc_t o_exc,
  output logic o_branch_link,
  output logic [31:0] o_instr_addr
);
  import pcs_pkg::*;
  // Drop every request; released buses other than the exception request show the inverse of their last value
  task automatic release_all();
    o_advance = 1'b0;
    o_instr_valid = 1'b0;
    o_instr = ~o_instr;
    o_first_reg = ~o_first_reg;
    o_imm_operand = ~o_imm_operand;
    o_reg_operand = ~o_reg_operand;
    o_write = '{kind: PCS_WR_NONE, value: ~o_write.value};
    o_restore_is_return = 1'b0;
    o_data = '{valid: 1'b0, addr: ~o_data.addr};
    o_exc.valid = 1'b0;
    o_branch_link = 1'b0;
    o_instr_addr = ~o_instr_addr;
  endtask
  // Keep a request up for exactly one rising edge
  task automatic hold_one();
    @(negedge i_clk_sys);
    release_all();
  endtask
  // Status-write compare; the unselected operand carries a decoy value
  task automatic status_write(input logic [3:0] cond, input pcs_op_t op, input logic imm,
      input logic [31:0] first, input logic [31:0] opnd);
    @(negedge i_clk_sys);
    o_instr_valid = 1'b1;
    o_instr = {cond, 2'b00, imm, 2'b10, op, 1'b1, 4'h0, 4'hf, 12'h000};
    o_first_reg = first;
    o_imm_operand = imm ? opnd : ~opnd;
    o_reg_operand = imm ? ~opnd : opnd;
    hold_one();
  endtask
  // Write into the combined register from an instruction result
  task automatic write(input pcs_wr_t kind, input logic [31:0] val, input logic ret);
    @(negedge i_clk_sys);
    o_write = '{kind: kind, value: val};
    o_restore_is_return = ret;
    hold_one();
  endtask
  // Software resume after an address fault: link minus eight with restore
  task automatic resume(input logic [31:0] link);
    write(PCS_WR_PC_STATUS, link - 32'h00000008, 1'b1);
  endtask
  // Data access from the instruction at iaddr
  task automatic access(input logic [31:0] addr, input logic [31:0] iaddr);
    @(negedge i_clk_sys);
    o_data = '{valid: 1'b1, addr: addr};
    o_instr_addr = iaddr;
    hold_one();
  endtask
  // Other exception entry into supervisor mode
  task automatic exc(input logic [31:0] vec);
    @(negedge i_clk_sys);
    o_exc = '{valid: 1'b1, vector: vec, set_imask: 1'b1, set_fmask: 1'b0, mode: PCS_MODE_SVC};
    hold_one();
  endtask
  // Sequential step or branch with link
  task automatic strobe(input logic adv, input logic bl);
    @(negedge i_clk_sys);
    o_advance = adv;
    o_branch_link = bl;
    hold_one();
  endtask
  // Defined levels from time zero
  initial begin
    o_instr = '0;
    o_first_reg = '0;
    o_imm_operand = '0;
    o_reg_operand = '0;
    o_write = '0;
    o_data = '0;
    o_exc = '0;
    o_instr_addr = '0;
    release_all();
  end
endmodule
`default_nettype wire

// file: sim/pcs_tb.sv
// Self-checking bench for the combined program counter and status register
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pcs_pkg::*;
  logic clk_sys = 1'b0; // 10 MHz core clock
  logic reset = 1'b1; // Synchronous reset
  logic adv, iv, rr, bl;
  logic [31:0] instr, fr, imm, rg, ia;
  pcs_write_t wr;
  pcs_data_access_t da;
  pcs_exc_t ex;
  logic [31:0] comb, fv, sv, st, fa, lv;
  logic lwe, lsvc, aexc, taken;
  logic [1:0] mode;
  int bad_count = 0; // Mismatches
  int checked = 0; // Comparisons
  logic [31:0] e, a, b, res, lk; // Expected register and scratch
  always #50 clk_sys = ~clk_sys;
  pcs_stream_model m (.i_clk_sys(clk_sys), .o_advance(adv), .o_instr_valid(iv),
    .o_instr(instr), .o_first_reg(fr), .o_imm_operand(imm), .o_reg_operand(rg),
    .o_write(wr), .o_restore_is_return(rr), .o_data(da), .o_exc(ex),
    .o_branch_link(bl), .o_instr_addr(ia));
  pcs_core_reg dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_advance(adv),
    .i_instr_valid(iv), .i_instr(instr), .i_first_reg(fr), .i_imm_operand(imm),
    .i_reg_operand(rg), .i_write(wr), .i_restore_is_return(rr), .i_data(da), .i_exc(ex),
    .i_branch_link(bl), .i_instr_addr(ia), .o_combined(comb), .o_first_operand_view(fv),
    .o_second_operand_view(sv), .o_store_value(st), .o_fetch_addr(fa), .o_link_we(lwe),
    .o_link_value(lv), .o_link_is_svc(lsvc), .o_addr_exception(aexc),
    .o_status_write_taken(taken), .o_mode(mode));
  // Compare 32-bit values
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare single flags
  task automatic cmp1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  // All views of the register against the expected value
  task automatic check_reg();
    cmp32("combined", e, comb);
    cmp32("first view", {6'h00, e[25:2], 2'b00}, fv);
    cmp32("second view", e, sv);
    cmp32("store", e, st);
    cmp32("fetch", {6'h00, e[25:2], 2'b00}, fa);
    cmp32("mode", {30'h0, e[1:0]}, {30'h0, mode});
  endtask
  // Fault from the instruction at 0x1000, expected state updated
  task automatic fault(input logic [31:0] addr);
    m.access(addr, 32'h00001000);
    lk = {e[31:26], 24'h000401, e[1:0]};
    e = {e[31:28], 1'b1, e[26], 24'h000005, 2'b11};
    check_reg();
    cmp1("addr exc", 1'b1, aexc);
    cmp1("link we", 1'b1, lwe);
    cmp1("link svc", 1'b1, lsvc);
    cmp32("link", lk, lv);
  endtask
  // Counts and verdict
  task automatic end_sim();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
  // Test sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    e = 32'h0c000003;
    check_reg();
    m.strobe(1'b1, 1'b0);
    e[25:2] = e[25:2] + 24'h000001;
    check_reg();
    $display("test reset and step done");
    a = 32'h5c000003;
    b = 32'h94000002;
    for (int i = 0; i < 4; i++) begin
      m.status_write(4'he, pcs_op_t'(i[1:0]), i[0], a, b);
      res = (i == 0) ? (a & b) : (i == 1) ? (a ^ b) : (i == 2) ? (a - b) : (a + b);
      e = {res[31:26], e[25:2], res[1:0]};
      check_reg();
      cmp1("taken", 1'b1, taken);
    end
    m.status_write(e[30] ? 4'h1 : 4'h0, PCS_OP_XOR, 1'b1, a, b);
    check_reg();
    cmp1("taken", 1'b0, taken);
    $display("test status writes done");
    m.status_write(4'he, PCS_OP_AND, 1'b1, 32'h0, 32'h0);
    e = {6'h00, e[25:2], 2'b00};
    m.status_write(4'he, PCS_OP_XOR, 1'b0, 32'hf0000003, 32'h0);
    e = {4'hf, e[27:0]};
    check_reg();
    m.write(PCS_WR_PC_STATUS, 32'h0c000103, 1'b0);
    e = {4'h0, e[27:26], 24'h000040, e[1:0]};
    check_reg();
    m.write(PCS_WR_PC_ONLY, 32'hfbfffff0, 1'b0);
    e = {e[31:26], 24'hfffffc, e[1:0]};
    check_reg();
    m.write(PCS_WR_PC_STATUS, 32'h8c000042, 1'b1);
    e = 32'h8c000042;
    check_reg();
    $display("test user mode done");
    m.write(PCS_WR_STATUS_ONLY, 32'h40000001, 1'b0);
    e = {6'h10, e[25:2], 2'b01};
    check_reg();
    m.write(PCS_WR_STATUS_ONLY, 32'hfc000000, 1'b0);
    e = {6'h3f, e[25:2], 2'b00};
    check_reg();
    m.write(PCS_WR_STATUS_ONLY, 32'h00000003, 1'b0);
    e = {4'h0, e[27:0]};
    check_reg();
    $display("test status only writes done");
    m.access(32'h03fffffc, 32'h00000100);
    check_reg();
    cmp1("addr exc", 1'b0, aexc);
    for (int k = 26; k < 32; k++) begin
      fault(32'h00000001 << k);
    end
    m.resume(lv);
    e = lk - 32'h00000008;
    check_reg();
    $display("test address faults done");
    lk = e;
    m.exc(32'h00000008);
    e = {e[31:28], 1'b1, e[26], 24'h000002, 2'b11};
    check_reg();
    cmp1("exc we", 1'b1, lwe);
    cmp1("exc svc", 1'b1, lsvc);
    cmp32("exc link", lk, lv);
    lk = e;
    m.strobe(1'b0, 1'b1);
    cmp1("bl we", 1'b1, lwe);
    cmp1("bl svc", 1'b0, lsvc);
    cmp32("bl link", lk, lv);
    $display("test links done");
    end_sim();
  end
endmodule
`default_nettype wire
